// [hdl/pot_wiper_defines.svh]
// Purpose: named constants for the wiper register and its serial port
// Assumes: included by its bare name, once per compilation unit
// Notes: definitions only
`ifndef POT_WIPER_DEFINES_SVH
`define POT_WIPER_DEFINES_SVH

// ---------------------------------------------------------------------------
// wiper register values
// ---------------------------------------------------------------------------
`define WIPER_WIDTH 7
`define WIPER_DEFAULT 7'h3f
`define WIPER_ZERO_SCALE 7'h00
`define WIPER_FULL_SCALE 7'h7f

// ---------------------------------------------------------------------------
// serial framing
// ---------------------------------------------------------------------------
`define BIT_COUNT_WIDTH 4
`define BYTE_BITS 4'h8
`define SLAVE_ADDR_DEFAULT 7'h2e
`define READ_BIT_POS 0

`endif

// [hdl/pot_wiper_pkg.sv]
// Purpose: shared types for the wiper register block
// Assumes: nothing beyond the defines header
// Notes: state codes are one-hot
package pot_wiper_pkg;

   // serial command states, one-hot
   typedef enum logic [6:0]
   {
      ST_IGNORE = 7'h01,
      ST_ADDR = 7'h02,
      ST_ADDR_ACK = 7'h04,
      ST_WR_DATA = 7'h08,
      ST_WR_ACK = 7'h10,
      ST_RD_DATA = 7'h20,
      ST_RD_ACK = 7'h40
   } serial_state_e;

endpackage

// [hdl/pot_wiper_power_reset.sv]
// Purpose: volatile wiper register with supply reset and serial slave port
// Assumes: pins and supply_ok are asynchronous; ref_clk far above bus rate
// Notes: analog network not modelled; tap flags show the chain ends
//
// Function
// (RL1) supply rise loads 3Fh, then allows operation
// (RL2) supply low: serial port disabled, bus ignored
// (RL3) brown-out marks wiper value unknown until reload
// (RL4) value 00h selects zero-scale tap, terminal B
// (RL5) value 7Fh selects full-scale tap, seven bits
// (RL6) stop enters static state, start leaves it
// (RL7) low-but-valid supply still serves reads and writes
// (RL8) read returns last write or reset default
// (RL9) start/stop: data edge while clock high
// (RL10) never stretch the serial clock
// (RL11) invalid command: release data, wait for start
`timescale 1ns/1ps
`include "pot_wiper_defines.svh"

module pot_wiper_power_reset
   import pot_wiper_pkg::*;
#(
   parameter logic [`WIPER_WIDTH-1:0] SLAVE_ADDR = `SLAVE_ADDR_DEFAULT
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic supply_ok,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe_n,
   output logic sda_out,
   output logic sda_oe_n,
   output logic [`WIPER_WIDTH-1:0] wiper_tap,
   output logic at_zero_scale,
   output logic at_full_scale,
   output logic wiper_unknown,
   output logic serial_enabled,
   output logic bus_static
);

   // ------------------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------------------
   logic [2:0] scl_sync_reg;
   logic [2:0] sda_sync_reg;
   logic [2:0] sup_sync_reg;
   logic scl_reg;
   logic sda_reg;
   logic sup_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic sup_prev_reg;

   // three stages; a level counts only once stages two and three agree,
   // which also rejects single-sample glitches on the pins
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         sup_sync_reg <= 3'h0;
      end
      else if (clk_en)
      begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
         sup_sync_reg <= {sup_sync_reg[1:0], supply_ok};
      end
   end

   // agreed levels and their previous values
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         scl_reg <= 1'h1;
         sda_reg <= 1'h1;
         sup_reg <= 1'h0;
         scl_prev_reg <= 1'h1;
         sda_prev_reg <= 1'h1;
         sup_prev_reg <= 1'h0;
      end
      else if (clk_en)
      begin
         if (scl_sync_reg[1] == scl_sync_reg[2])
            scl_reg <= scl_sync_reg[2];
         if (sda_sync_reg[1] == sda_sync_reg[2])
            sda_reg <= sda_sync_reg[2];
         if (sup_sync_reg[1] == sup_sync_reg[2])
            sup_reg <= sup_sync_reg[2];
         scl_prev_reg <= scl_reg;
         sda_prev_reg <= sda_reg;
         sup_prev_reg <= sup_reg;
      end
   end

   // ------------------------------------------------------------------------
   // bus events
   // ------------------------------------------------------------------------
   wire scl_rise = scl_reg & ~scl_prev_reg;
   wire scl_fall = ~scl_reg & scl_prev_reg;
   wire both_high = scl_reg & scl_prev_reg;
   wire start_seen = both_high & sda_prev_reg & ~sda_reg; // RL9
   wire stop_seen = both_high & ~sda_prev_reg & sda_reg; // RL9
   wire supply_rise = sup_reg & ~sup_prev_reg;
   wire supply_low = ~sup_reg;

   // ------------------------------------------------------------------------
   // serial command engine
   // ------------------------------------------------------------------------
   serial_state_e state_reg;
   serial_state_e state_next;
   logic [`BIT_COUNT_WIDTH-1:0] bit_cnt_reg;
   logic [`BIT_COUNT_WIDTH-1:0] bit_cnt_next;
   logic [7:0] rx_reg;
   logic [7:0] rx_next;
   logic [7:0] tx_reg;
   logic [7:0] tx_next;
   logic read_reg;
   logic read_next;
   logic more_reg;
   logic more_next;
   logic drive_low_reg;
   logic drive_low_next;
   logic wr_commit;
   logic [`WIPER_WIDTH-1:0] wiper_reg;

   wire byte_done = (bit_cnt_reg == `BYTE_BITS);
   wire addr_match = (rx_reg[7:1] == SLAVE_ADDR);
   wire [7:0] read_byte = {1'h0, wiper_reg}; // RL8

   // one bit moves per scl edge and the engine answers within a few
   // ref_clk cycles, so scl is never held low by this device
   always_comb
   begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      rx_next = rx_reg;
      tx_next = tx_reg;
      read_next = read_reg;
      more_next = more_reg;
      drive_low_next = drive_low_reg;
      wr_commit = 1'h0;
      if (supply_low)
      begin
         state_next = ST_IGNORE; // RL2
         drive_low_next = 1'h0; // RL2
      end
      else if (start_seen)
      begin
         state_next = ST_ADDR;
         bit_cnt_next = '0;
         drive_low_next = 1'h0;
      end
      else if (stop_seen)
      begin
         state_next = ST_IGNORE;
         drive_low_next = 1'h0;
      end
      else if (scl_rise)
      begin
         case (state_reg)
            ST_ADDR, ST_WR_DATA:
            begin
               rx_next = {rx_reg[6:0], sda_reg};
               bit_cnt_next = bit_cnt_reg + 1'h1;
            end
            ST_RD_DATA: bit_cnt_next = bit_cnt_reg + 1'h1;
            ST_RD_ACK: more_next = ~sda_reg;
            default: state_next = state_reg;
         endcase
      end
      else if (scl_fall)
      begin
         case (state_reg)
            ST_ADDR:
               if (byte_done)
               begin
                  // general call and foreign addresses get no ack
                  if (addr_match)
                  begin
                     state_next = ST_ADDR_ACK;
                     read_next = rx_reg[`READ_BIT_POS];
                     drive_low_next = 1'h1;
                  end
                  else
                     state_next = ST_IGNORE; // RL11
               end
            ST_ADDR_ACK, ST_RD_ACK:
            begin
               bit_cnt_next = '0;
               if (state_reg == ST_RD_ACK && !more_reg)
               begin
                  state_next = ST_IGNORE;
                  drive_low_next = 1'h0;
               end
               else if (read_reg)
               begin
                  state_next = ST_RD_DATA;
                  tx_next = read_byte; // RL8
                  drive_low_next = ~read_byte[7];
               end
               else
               begin
                  state_next = ST_WR_DATA;
                  drive_low_next = 1'h0;
               end
            end
            ST_WR_DATA:
               if (byte_done)
               begin
                  wr_commit = 1'h1; // RL7
                  state_next = ST_WR_ACK;
                  drive_low_next = 1'h1;
               end
            ST_WR_ACK:
            begin
               state_next = ST_WR_DATA;
               bit_cnt_next = '0;
               drive_low_next = 1'h0;
            end
            ST_RD_DATA:
               if (byte_done)
               begin
                  state_next = ST_RD_ACK;
                  drive_low_next = 1'h0;
               end
               else
               begin
                  tx_next = {tx_reg[6:0], 1'h0};
                  drive_low_next = ~tx_reg[6];
               end
            default: drive_low_next = 1'h0; // RL11
         endcase
      end
   end

   // engine state
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_reg <= ST_IGNORE;
         bit_cnt_reg <= '0;
         rx_reg <= 8'h00;
         tx_reg <= 8'h00;
         read_reg <= 1'h0;
         more_reg <= 1'h0;
         drive_low_reg <= 1'h0;
      end
      else if (clk_en)
      begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         rx_reg <= rx_next;
         tx_reg <= tx_next;
         read_reg <= read_next;
         more_reg <= more_next;
         drive_low_reg <= drive_low_next;
      end
   end

   // ------------------------------------------------------------------------
   // wiper register and supply state
   // ------------------------------------------------------------------------
   wire [`WIPER_WIDTH-1:0] wiper_next =
      supply_rise ? `WIPER_DEFAULT :
      wr_commit ? rx_reg[`WIPER_WIDTH-1:0] : wiper_reg;

   // reset load wins over a write landing in the same cycle
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         wiper_reg <= `WIPER_DEFAULT; // RL1
         wiper_unknown <= 1'h0;
      end
      else if (clk_en)
      begin
         wiper_reg <= wiper_next; // RL1
         if (supply_low)
            wiper_unknown <= 1'h1; // RL3
         else if (supply_rise)
            wiper_unknown <= 1'h0; // RL3
      end
   end

   // ------------------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------------------
   // tap flags track wiper_next so they line up with wiper_tap
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         wiper_tap <= `WIPER_DEFAULT;
         at_zero_scale <= 1'h0;
         at_full_scale <= 1'h0;
         serial_enabled <= 1'h0;
         bus_static <= 1'h1;
      end
      else if (clk_en)
      begin
         wiper_tap <= wiper_next;
         at_zero_scale <= (wiper_next == `WIPER_ZERO_SCALE); // RL4
         at_full_scale <= (wiper_next == `WIPER_FULL_SCALE); // RL5
         serial_enabled <= ~supply_low; // RL2
         // a disabled port counts as inactive, so bus traffic seen
         // while the supply is low cannot move this flag
         if (stop_seen || supply_low)
            bus_static <= 1'h1; // RL6
         else if (start_seen)
            bus_static <= 1'h0; // RL6
      end
   end

   // open-drain pins: output level fixed low, enable low means pulling
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sda_out <= 1'h0;
         sda_oe_n <= 1'h1;
         scl_out <= 1'h0;
         scl_oe_n <= 1'h1;
      end
      else if (clk_en)
      begin
         sda_out <= 1'h0;
         sda_oe_n <= ~drive_low_next;
         scl_out <= 1'h0;
         scl_oe_n <= 1'h1; // RL10
      end
   end

endmodule

// [test/pot_wiper_chk.sv]
// Purpose: assertions on the wiper block's ports
// Assumes: one clock domain, pins filtered 3-4 cycles
// Notes: bound to the design after endmodule
`timescale 1ns/1ps
`include "pot_wiper_defines.svh"
module pot_wiper_chk
   import pot_wiper_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic supply_ok,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic scl_oe_n,
   input wire logic sda_oe_n,
   input wire logic [`WIPER_WIDTH-1:0] wiper_tap,
   input wire logic at_zero_scale,
   input wire logic at_full_scale,
   input wire logic wiper_unknown,
   input wire logic serial_enabled,
   input wire logic bus_static
);
   // ----------
   // assertions
   // ----------
   // ranges allow for the pin filter lag
   default clocking cb @(posedge ref_clk); endclocking
   // frozen cycles are not judged: the block ignores its pins then
   default disable iff (reset || !clk_en);
   AST_NO_STRETCH: assert property (scl_oe_n)
      else $error("clock line driven");
   AST_ZERO_TAP: assert property
      (at_zero_scale == (wiper_tap == 7'h00)) else $error("zero flag");
   AST_FULL_TAP: assert property
      (at_full_scale == (wiper_tap == 7'h7f)) else $error("full flag");
   AST_DROP: assert property ($fell(supply_ok) |->
      ##[2:8] (wiper_unknown && !serial_enabled)) else $error("drop");
   AST_RELOAD: assert property ($rose(supply_ok) |->
      ##[2:8] (wiper_tap == 7'h3f && !wiper_unknown)) else $error("reload");
   AST_START: assert property
      (serial_enabled && scl_in && $past(scl_in) && $fell(sda_in)
      |-> ##[1:8] !bus_static) else $error("start missed");
   AST_STOP: assert property
      (serial_enabled && scl_in && $past(scl_in) && $rose(sda_in)
      |-> ##[1:8] bus_static) else $error("stop missed");
   AST_DRIVE_LOW_PHASE: assert property
      ($fell(sda_oe_n) |-> !scl_in && !$past(scl_in, 4))
      else $error("data moved with clock high");
   // main scenarios reached
   cover property (!sda_oe_n && wiper_tap == 7'h00);
   cover property (wiper_unknown && !bus_static);
   cover property ($rose(supply_ok) ##8 serial_enabled);
endmodule

bind pot_wiper_power_reset pot_wiper_chk chk (.ref_clk, .reset, .clk_en,
   .supply_ok, .scl_in, .sda_in, .scl_oe_n, .sda_oe_n, .wiper_tap,
   .at_zero_scale, .at_full_scale, .wiper_unknown, .serial_enabled,
   .bus_static);

// [test/i2c_master_model.sv]
// Purpose: bus master on the wiper block's serial pins
// Assumes: open-drain lines resolved with pull-ups in the bench
// Notes: phase is cycles per pin setting; raise it for a slow master
`timescale 1ns/1ps
module i2c_master_model
(
   input wire logic ref_clk,
   input wire logic sda_line,
   output logic scl_m,
   output logic sda_m
);
   int phase = 8;
   initial
   begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   // ----------
   // pin tasks
   // ----------
   // one pin setting, held a whole phase so the filter keeps it
   task automatic step(input logic c, input logic d);
      @(posedge ref_clk);
      scl_m <= c;
      sda_m <= d;
      repeat (phase - 1) @(posedge ref_clk);
   endtask
   // data only moves with the clock low, else a false condition
   task automatic start();
      step(1'b0, sda_m);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask
   task automatic stop();
      step(1'b0, sda_m);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   // nine bits, msb first; a 1 releases the line to read it
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--)
      begin
         step(1'b0, sda_m);
         step(1'b0, tx[i]);
         step(1'b1, tx[i]);
         rx[i] = sda_line;
      end
   endtask
endmodule

// [test/pot_wiper_power_reset_tb.sv]
// Purpose: self-checking bench for the wiper block
// Assumes: master model on the pins, pull-ups on both lines
// Notes: expectations come from a small wiper model here
`timescale 1ns/1ps
`include "pot_wiper_defines.svh"
module pot_wiper_power_reset_tb
   import pot_wiper_pkg::*;
;
   logic ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, supply_ok = 1'b1;
   logic scl_m, sda_m, scl_out, scl_oe_n, sda_out, sda_oe_n, wiper_unknown;
   logic at_zero_scale, at_full_scale, serial_enabled, bus_static;
   logic [`WIPER_WIDTH-1:0] wiper_tap, model;
   logic powered = 1'b1;
   logic [8:0] rx;
   logic [7:0] q[$];
   int n_errors = 0, comparisons = 0;
   wire logic scl_line, sda_line;
   // open drain: low if any party pulls
   assign scl_line = scl_m & (scl_oe_n | scl_out);
   assign sda_line = sda_m & (sda_oe_n | sda_out);
   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end
   pot_wiper_power_reset uut (.ref_clk, .reset, .clk_en, .supply_ok,
      .scl_in(scl_line), .sda_in(sda_line), .scl_out, .scl_oe_n, .sda_out,
      .sda_oe_n, .wiper_tap, .at_zero_scale, .at_full_scale,
      .wiper_unknown, .serial_enabled, .bus_static);
   i2c_master_model m (.ref_clk, .sda_line, .scl_m, .sda_m);
   // ----------
   // tasks
   // ----------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d, errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // write every byte of q; a miss must leave the model alone
   task automatic wr(input logic [6:0] a);
      logic hit;
      hit = powered && a == `SLAVE_ADDR_DEFAULT;
      m.start();
      check(bus_static, !powered);
      m.xfer({a, 2'b01}, rx);
      check(rx[0], !hit);
      foreach (q[i])
      begin
         m.xfer({q[i], 1'b1}, rx);
         if (hit)
            model = q[i][6:0];
         check(rx[0], !hit);
         check(wiper_tap, model);
         check(at_zero_scale, model == 7'h00);
         check(at_full_scale, model == 7'h7f);
      end
      m.stop();
      check(bus_static, 1'b1);
      $display("write to %h ended", a);
   endtask
   task automatic rd(input int n);
      m.start();
      m.xfer({`SLAVE_ADDR_DEFAULT, 2'b11}, rx);
      check(rx[0], 1'b0);
      check({scl_out, sda_out}, 2'b00);
      for (int i = 1; i <= n; i++)
      begin
         m.xfer({8'hff, i == n}, rx);
         check(rx[8:1], {1'b0, model});
      end
      m.stop();
      $display("read of %0d ended", n);
   endtask
   // ----------
   // sequence
   // ----------
   initial
   begin
      void'($urandom(32'h2a0e8d85));
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (12) @(posedge ref_clk);
      model = `WIPER_DEFAULT;
      check(wiper_tap, model);
      rd(1);
      q = {8'h80, 8'hff, 8'h00};
      wr(`SLAVE_ADDR_DEFAULT);
      rd(2);
      // supply dip while clk_en is low must leave no trace
      clk_en <= 1'b0;
      repeat (2) @(posedge ref_clk);
      supply_ok <= 1'b0;
      repeat (10) @(posedge ref_clk);
      supply_ok <= 1'b1;
      repeat (10) @(posedge ref_clk);
      clk_en <= 1'b1;
      repeat (8) @(posedge ref_clk);
      check(wiper_unknown, 1'b0);
      check(serial_enabled, 1'b1);
      check(wiper_tap, model);
      $display("clock enable freeze ended");
      for (int i = 0; i < 6; i++)
      begin
         m.phase = (i == 5) ? 20 : 8;
         q = {8'($urandom), 8'($urandom)};
         wr((i % 2) ? 7'($urandom) : `SLAVE_ADDR_DEFAULT);
         rd(1);
      end
      wr(7'h00);
      // supply falls with a write cut short
      m.start();
      m.xfer({`SLAVE_ADDR_DEFAULT, 2'b01}, rx);
      m.step(1'b0, 1'b1);
      supply_ok <= 1'b0;
      powered = 1'b0;
      repeat (12) @(posedge ref_clk);
      check(wiper_unknown, 1'b1);
      check(serial_enabled, 1'b0);
      wr(`SLAVE_ADDR_DEFAULT);
      supply_ok <= 1'b1;
      powered = 1'b1;
      model = `WIPER_DEFAULT;
      repeat (12) @(posedge ref_clk);
      check(wiper_unknown, 1'b0);
      check(wiper_tap, model);
      wr(`SLAVE_ADDR_DEFAULT);
      rd(1);
      test_done();
   end
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      n_errors++;
      test_done();
   end
endmodule
